// [logic/pvc_pkg.sv]
// constants, encodings and types shared by the process value conditioner
package pvc_pkg;
  localparam int PVC_NIN = 4;
  localparam int PVC_SW = 2;
  localparam int PVC_DW = 32;
  localparam int PVC_WW = 64;
  localparam int PVC_UW = 8;
  localparam int PVC_FW = 10;
  localparam int PVC_PW = 8;
  // values are signed thousandths of the engineering unit
  localparam logic signed [PVC_WW-1:0] PVC_VAL_MAX = 64'sh0000_0000_05F5_DD18;
  localparam logic signed [PVC_WW-1:0] PVC_MILLI = 64'sh0000_0000_0000_03E8;
  // filter setting in tenths of a second
  localparam logic [PVC_FW-1:0] PVC_FILT_MAX = 10'h258;
  localparam logic [PVC_FW-1:0] PVC_FILT_STEP = 10'h001;
  // sample period equals one filter step of 0.1 s
  localparam logic [31:0] PVC_CLK_HZ = 32'h017D_7840;
  localparam logic [31:0] PVC_MS_PER_S = 32'h0000_03E8;
  localparam logic [31:0] PVC_SAMPLE_MS = 32'h0000_0064;
  localparam int PVC_SAMPLE_CYCLES = int'(PVC_CLK_HZ / PVC_MS_PER_S * PVC_SAMPLE_MS);
  // pressure setting in tenths of psi
  localparam logic [PVC_PW-1:0] PVC_PRES_MIN = 8'h64;
  localparam logic [PVC_PW-1:0] PVC_PRES_MAX = 8'hA0;
  localparam logic [PVC_UW-1:0] PVC_UNITLESS = 8'h00;
  localparam logic [PVC_UW-1:0] PVC_UNIT_RH = 8'h01;
  // saturation pressure table, 1e-5 psi, from 0 F in 25 F steps
  localparam logic signed [PVC_WW-1:0] PVC_ES_STEP = 64'sh0000_0000_0000_61A8;
  localparam logic [3:0] PVC_ES_LAST = 4'hE;
  localparam logic signed [PVC_WW-1:0] PVC_PSY_DEN = 64'sh0000_0000_0029_32E0;
  localparam logic signed [PVC_WW-1:0] PVC_P_SCALE = 64'sh0000_0000_0000_2710;
  localparam logic signed [PVC_WW-1:0] PVC_RH_SCALE = 64'sh0000_0000_0001_86A0;
  localparam logic [31:0] PVC_ES_TAB [16] = '{
    32'h0000_073A, 32'h0000_1838, 32'h0000_4588, 32'h0000_A7F8,
    32'h0001_72B4, 32'h0002_F6FC, 32'h0005_AD20, 32'h000A_4100,
    32'h0011_97E8, 32'h001C_DEA0, 32'h002D_8070, 32'h0045_4660,
    32'h0066_3BE0, 32'h0092_A310, 32'h00CD_6220, 32'h0119_5F40};
  localparam logic [6:0] PVC_DIV_STEPS = 7'h40;

  typedef enum logic [2:0] {
    PVC_F_OFF = 3'b000,
    PVC_F_BACKUP = 3'b001,
    PVC_F_AVG = 3'b010,
    PVC_F_XOVER = 3'b011,
    PVC_F_WETDRY = 3'b100,
    PVC_F_SWITCH = 3'b101,
    PVC_F_DIFF = 3'b110,
    PVC_F_RATIO = 3'b111
  } pvc_func_t;

  typedef enum logic [2:0] {
    PVC_S_IDLE = 3'b000,
    PVC_S_CALC = 3'b001,
    PVC_S_QWAIT = 3'b010,
    PVC_S_FILT = 3'b011,
    PVC_S_FWAIT = 3'b100,
    PVC_S_OUT = 3'b101
  } pvc_fsm_t;
endpackage

// [logic/pvc_div_if.sv]
// request and answer signals of the shared divider
`timescale 1ns/1ps
interface pvc_div_if;
  import pvc_pkg::*;
  logic start;
  logic signed [PVC_WW-1:0] num;
  logic signed [PVC_WW-1:0] den;
  logic done;
  logic signed [PVC_WW-1:0] quot;
  modport req (output start, output num, output den, input done, input quot);
  modport srv (input start, input num, input den, output done, output quot);
endinterface

// [logic/pvc_divider.sv]
// sequential signed divider, one quotient bit per clock
`timescale 1ns/1ps
module pvc_divider
  import pvc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  pvc_div_if.srv bus
);
  typedef struct packed {
    logic busy;
    logic [6:0] cnt;
    logic [PVC_WW-1:0] rem;
    logic [PVC_WW-1:0] quo;
    logic [PVC_WW-1:0] den;
    logic neg;
    logic done;
    logic signed [PVC_WW-1:0] res;
  } pvc_div_state_t;

  pvc_div_state_t st_reg;
  pvc_div_state_t st_next;
  logic [PVC_WW:0] trial;
  logic [PVC_WW-1:0] quoNew;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    trial = '0;
    quoNew = '0;
    if (bus.start) begin
      st_next.busy = 1'b1;
      st_next.cnt = PVC_DIV_STEPS;
      st_next.neg = bus.num[PVC_WW-1] ^ bus.den[PVC_WW-1];
      st_next.quo = bus.num[PVC_WW-1] ? -bus.num : bus.num;
      st_next.den = bus.den[PVC_WW-1] ? -bus.den : bus.den;
      st_next.rem = '0;
    end else if (st_reg.busy) begin
      trial = {st_reg.rem, st_reg.quo[PVC_WW-1]} - {1'b0, st_reg.den};
      quoNew = {st_reg.quo[PVC_WW-2:0], ~trial[PVC_WW]};
      st_next.rem = trial[PVC_WW] ? {st_reg.rem[PVC_WW-2:0], st_reg.quo[PVC_WW-1]}
                                  : trial[PVC_WW-1:0];
      st_next.quo = quoNew;
      st_next.cnt = st_reg.cnt - 7'h01;
      if (st_reg.cnt == 7'h01) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.res = st_reg.neg ? -quoNew : quoNew;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.done = st_reg.done;
  assign bus.quot = st_reg.res;
endmodule

// [logic/pvc_humidity.sv]
// psychrometric numerator and denominator for relative humidity
`timescale 1ns/1ps
module pvc_humidity
  import pvc_pkg::*;
(
  input wire logic signed [PVC_DW-1:0] dryTemp,
  input wire logic signed [PVC_DW-1:0] wetTemp,
  input wire logic [PVC_PW-1:0] pressTenth,
  output logic signed [PVC_WW-1:0] rhNumer,
  output logic signed [PVC_WW-1:0] rhDenom
);
  function automatic logic signed [PVC_WW-1:0] satPress(input logic signed [PVC_DW-1:0] t);
    logic signed [PVC_WW-1:0] tc;
    logic signed [PVC_WW-1:0] q;
    logic [3:0] idx;
    logic signed [PVC_WW-1:0] lo;
    logic signed [PVC_WW-1:0] hi;
    tc = (t < 0) ? '0 : PVC_WW'(t);
    q = tc / PVC_ES_STEP;
    idx = (q > signed'(PVC_WW'(PVC_ES_LAST))) ? PVC_ES_LAST : q[3:0];
    tc = tc - signed'(PVC_WW'(idx)) * PVC_ES_STEP;
    lo = signed'(PVC_WW'(PVC_ES_TAB[idx]));
    hi = signed'(PVC_WW'(PVC_ES_TAB[idx + 4'h1]));
    return lo + (hi - lo) * tc / PVC_ES_STEP;
  endfunction

  logic signed [PVC_WW-1:0] esWet;
  logic signed [PVC_WW-1:0] depress;
  logic signed [PVC_WW-1:0] vapor;

  // vapor pressure from wet-bulb depression, then ratio to dry saturation
  always_comb begin
    esWet = satPress(wetTemp);
    depress = signed'(PVC_WW'(pressTenth)) * PVC_P_SCALE
              * (PVC_WW'(dryTemp) - PVC_WW'(wetTemp)) / PVC_PSY_DEN;
    vapor = esWet - depress;
    if (vapor < 0) begin
      vapor = '0;
    end
    rhNumer = vapor * PVC_RH_SCALE;
    rhDenom = satPress(dryTemp);
  end
endmodule

// [logic/pvc_conditioner.sv]
// process value conditioner: function select, first-order filter and offset
`timescale 1ns/1ps
module pvc_conditioner
  import pvc_pkg::*;
#(
  parameter int UW = PVC_UW,
  parameter int SAMPLE_CYCLES = PVC_SAMPLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [PVC_NIN-1:0][PVC_DW-1:0] pvIn,
  input wire logic [PVC_NIN-1:0][UW-1:0] unitIn,
  input wire logic [PVC_NIN-1:0] connIn,
  input wire logic [PVC_NIN-1:0] errIn,
  input wire logic inputSelectLine,
  input wire logic [2:0] funcSel,
  input wire logic [PVC_DW-1:0] offsetSet,
  input wire logic [PVC_FW-1:0] filterSet,
  input wire logic [PVC_DW-1:0] xoverPoint,
  input wire logic [PVC_DW-1:0] xoverBand,
  input wire logic [PVC_PW-1:0] pressSet,
  output logic [PVC_DW-1:0] pvOut,
  output logic [UW-1:0] unitOut,
  output logic errOut,
  output logic validOut
);
  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    pvc_fsm_t fsm;
    logic [31:0] tick;
    logic selMeta;
    logic selSync;
    logic signed [PVC_WW-1:0] qBase;
    logic signed [PVC_DW-1:0] raw;
    logic [UW-1:0] rawUnit;
    logic rawErr;
    logic primed;
    logic signed [PVC_DW-1:0] filtY;
    logic divStart;
    logic signed [PVC_WW-1:0] divNum;
    logic signed [PVC_WW-1:0] divDen;
    logic signed [PVC_DW-1:0] outVal;
    logic [UW-1:0] outUnit;
    logic outErr;
    logic outValid;
  } pvc_top_state_t;

  localparam logic [31:0] TICK_LAST = 32'(SAMPLE_CYCLES - 1);

  pvc_top_state_t st_reg;
  pvc_top_state_t st_next;

  function automatic logic signed [PVC_WW-1:0] clampVal(input logic signed [PVC_WW-1:0] v);
    if (v > PVC_VAL_MAX) begin
      return PVC_VAL_MAX;
    end else if (v < -PVC_VAL_MAX) begin
      return -PVC_VAL_MAX;
    end
    return v;
  endfunction

  function automatic logic signed [PVC_DW-1:0] sat(input logic signed [PVC_WW-1:0] v);
    logic signed [PVC_WW-1:0] hiLim;
    hiLim = PVC_WW'({1'b0, {(PVC_DW-1){1'b1}}});
    if (v > hiLim) begin
      return hiLim[PVC_DW-1:0];
    end else if (v < -hiLim - 1) begin
      return {1'b1, {(PVC_DW-1){1'b0}}};
    end
    return v[PVC_DW-1:0];
  endfunction

  // ********************************************************************
  // settings and per-input terms
  // ********************************************************************
  logic [PVC_NIN-1:0] okBit;
  logic signed [PVC_WW-1:0] sumTerm [PVC_NIN];
  logic signed [PVC_WW-1:0] offC;
  logic signed [PVC_WW-1:0] ptC;
  logic signed [PVC_WW-1:0] bwC;
  logic signed [PVC_WW-1:0] xLo;
  logic signed [PVC_WW-1:0] xHi;
  logic [PVC_FW-1:0] filtC;
  logic [PVC_PW-1:0] presC;
  logic signed [PVC_WW-1:0] aW;
  logic signed [PVC_WW-1:0] bW;
  logic signed [PVC_WW-1:0] sum;
  logic signed [PVC_WW-1:0] cnt;
  logic [PVC_SW-1:0] pick;
  logic found;
  logic [PVC_SW-1:0] swIdx;
  logic signed [PVC_WW-1:0] humNum;
  logic signed [PVC_WW-1:0] humDen;

  for (genvar i = 0; i < PVC_NIN; i++) begin : g_in
    assign okBit[i] = connIn[i] & ~errIn[i];
    assign sumTerm[i] = connIn[i] ? PVC_WW'(signed'(pvIn[i])) : '0;
  end

  always_comb begin
    offC = clampVal(PVC_WW'(signed'(offsetSet)));
    ptC = clampVal(PVC_WW'(signed'(xoverPoint)));
    bwC = PVC_WW'(signed'(xoverBand));
    bwC = clampVal(bwC < 0 ? -bwC : bwC);
    xLo = ptC - (bwC >>> 1);
    xHi = xLo + bwC;
    filtC = (filterSet > PVC_FILT_MAX) ? PVC_FILT_MAX : filterSet;
    presC = (pressSet < PVC_PRES_MIN) ? PVC_PRES_MIN :
            (pressSet > PVC_PRES_MAX) ? PVC_PRES_MAX : pressSet;
    aW = PVC_WW'(signed'(pvIn[0]));
    bW = PVC_WW'(signed'(pvIn[1]));
    sum = '0;
    cnt = '0;
    pick = '0;
    found = 1'b0;
    for (int i = 0; i < PVC_NIN; i++) begin
      sum = sum + sumTerm[i];
      cnt = cnt + PVC_WW'(connIn[i]);
    end
    for (int i = PVC_NIN - 1; i >= 0; i--) begin
      if (okBit[i]) begin
        pick = PVC_SW'(i);
        found = 1'b1;
      end
    end
    swIdx = st_reg.selSync ? PVC_SW'(1) : PVC_SW'(0);
  end

  // ********************************************************************
  // divider and humidity helpers
  // ********************************************************************
  pvc_div_if divBus ();

  assign divBus.start = st_reg.divStart;
  assign divBus.num = st_reg.divNum;
  assign divBus.den = st_reg.divDen;

  pvc_divider u_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .bus(divBus)
  );

  pvc_humidity u_hum (
    .dryTemp(pvIn[0]),
    .wetTemp(pvIn[1]),
    .pressTenth(presC),
    .rhNumer(humNum),
    .rhDenom(humDen)
  );

  // ********************************************************************
  // sequencer
  // ********************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.divStart = 1'b0;
    st_next.outValid = 1'b0;
    st_next.selMeta = inputSelectLine;
    st_next.selSync = st_reg.selMeta;
    case (st_reg.fsm)
      PVC_S_IDLE: begin
        if (st_reg.tick == '0) begin
          st_next.tick = TICK_LAST;
          st_next.fsm = PVC_S_CALC;
        end else begin
          st_next.tick = st_reg.tick - 32'h0000_0001;
        end
      end
      PVC_S_CALC: begin
        st_next.fsm = PVC_S_FILT;
        st_next.qBase = '0;
        st_next.raw = pvIn[0];
        st_next.rawUnit = unitIn[0];
        st_next.rawErr = ~okBit[0];
        case (pvc_func_t'(funcSel))
          PVC_F_OFF: begin
            st_next.raw = pvIn[0];
          end
          PVC_F_BACKUP: begin
            st_next.raw = pvIn[pick];
            st_next.rawUnit = unitIn[pick];
            st_next.rawErr = ~found;
          end
          PVC_F_AVG: begin
            st_next.rawUnit = unitIn[0];
            st_next.rawErr = ~|okBit;
            if (cnt != '0) begin
              st_next.divNum = sum;
              st_next.divDen = cnt;
              st_next.divStart = 1'b1;
              st_next.fsm = PVC_S_QWAIT;
            end
          end
          PVC_F_XOVER: begin
            st_next.rawErr = ~okBit[0] & ~okBit[1];
            if (aW <= xLo) begin
              st_next.raw = pvIn[0];
            end else if (aW >= xHi) begin
              st_next.raw = pvIn[1];
            end else begin
              st_next.qBase = aW;
              st_next.divNum = (bW - aW) * (aW - xLo);
              st_next.divDen = bwC;
              st_next.divStart = 1'b1;
              st_next.fsm = PVC_S_QWAIT;
            end
          end
          PVC_F_WETDRY: begin
            st_next.rawUnit = PVC_UNIT_RH;
            st_next.rawErr = (~okBit[0] & ~okBit[1]) | (humDen == '0);
            if (humDen != '0) begin
              st_next.divNum = humNum;
              st_next.divDen = humDen;
              st_next.divStart = 1'b1;
              st_next.fsm = PVC_S_QWAIT;
            end
          end
          PVC_F_SWITCH: begin
            st_next.raw = pvIn[swIdx];
            st_next.rawUnit = unitIn[swIdx];
            st_next.rawErr = ~okBit[swIdx];
          end
          PVC_F_DIFF: begin
            st_next.raw = sat(aW - bW);
            st_next.rawErr = ~okBit[0] & ~okBit[1];
          end
          PVC_F_RATIO: begin
            st_next.rawUnit = (unitIn[0] == unitIn[1]) ? PVC_UNITLESS : unitIn[0];
            st_next.rawErr = (~okBit[0] & ~okBit[1]) | (bW == '0);
            st_next.raw = '0;
            if (bW != '0) begin
              st_next.divNum = aW * PVC_MILLI;
              st_next.divDen = bW;
              st_next.divStart = 1'b1;
              st_next.fsm = PVC_S_QWAIT;
            end
          end
          default: begin
            st_next.raw = pvIn[0];
          end
        endcase
      end
      PVC_S_QWAIT: begin
        if (divBus.done) begin
          st_next.raw = sat(st_reg.qBase + divBus.quot);
          st_next.fsm = PVC_S_FILT;
        end
      end
      PVC_S_FILT: begin
        st_next.fsm = PVC_S_OUT;
        if (!st_reg.rawErr) begin
          if (filtC == '0 || !st_reg.primed) begin
            st_next.filtY = st_reg.raw;
            st_next.primed = 1'b1;
          end else begin
            st_next.divNum = (PVC_WW'(st_reg.raw) - PVC_WW'(st_reg.filtY))
                             * signed'(PVC_WW'(PVC_FILT_STEP));
            st_next.divDen = signed'(PVC_WW'(filtC)) + signed'(PVC_WW'(PVC_FILT_STEP));
            st_next.divStart = 1'b1;
            st_next.fsm = PVC_S_FWAIT;
          end
        end
      end
      PVC_S_FWAIT: begin
        if (divBus.done) begin
          st_next.filtY = sat(PVC_WW'(st_reg.filtY) + divBus.quot);
          st_next.fsm = PVC_S_OUT;
        end
      end
      PVC_S_OUT: begin
        st_next.outVal = sat(PVC_WW'(st_reg.filtY) + offC);
        st_next.outUnit = st_reg.rawUnit;
        st_next.outErr = st_reg.rawErr;
        st_next.outValid = 1'b1;
        st_next.fsm = PVC_S_IDLE;
      end
      default: begin
        st_next.fsm = PVC_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pvOut = st_reg.outVal;
  assign unitOut = st_reg.outUnit;
  assign errOut = st_reg.outErr;
  assign validOut = st_reg.outValid;

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_offset_added: assert property (
    st_reg.fsm == PVC_S_OUT |=> validOut && signed'(pvOut) == sat(PVC_WW'($past(st_reg.filtY)) + $past(offC))
  ) else $error("output is not filtered value plus offset");

  a_pass_top: assert property (
    st_reg.fsm == PVC_S_CALC && funcSel == PVC_F_OFF |=> st_reg.raw == $past(pvIn[0])
      && st_reg.rawUnit == $past(unitIn[0])
  ) else $error("pass-through does not follow the top input");

  a_filter_bypass: assert property (
    st_reg.fsm == PVC_S_FILT && filtC == '0 && !st_reg.rawErr
      |=> st_reg.filtY == $past(st_reg.raw) ##1 validOut
  ) else $error("zero filter time does not pass the value through");

  a_backup_first: assert property (
    st_reg.fsm == PVC_S_CALC && funcSel == PVC_F_BACKUP && okBit[0]
      |=> st_reg.raw == $past(pvIn[0]) && !st_reg.rawErr
  ) else $error("healthy primary input not chosen");

  a_backup_skip: assert property (
    st_reg.fsm == PVC_S_CALC && funcSel == PVC_F_BACKUP && !connIn[0] && okBit[1]
      |=> st_reg.raw == $past(pvIn[1]) && st_reg.rawUnit == $past(unitIn[1])
  ) else $error("unconnected primary not skipped");

  a_switch_off: assert property (
    st_reg.fsm == PVC_S_CALC && funcSel == PVC_F_SWITCH && !st_reg.selSync
      |=> st_reg.raw == $past(pvIn[0])
  ) else $error("select off does not choose input 1");

  a_diff_unit: assert property (
    st_reg.fsm == PVC_S_CALC && funcSel == PVC_F_DIFF
      |=> st_reg.raw == sat($past(aW) - $past(bW)) && st_reg.rawUnit == $past(unitIn[0])
  ) else $error("difference or its unit tag wrong");

  a_ratio_unitless: assert property (
    st_reg.fsm == PVC_S_CALC && funcSel == PVC_F_RATIO && unitIn[0] == unitIn[1]
      |=> st_reg.rawUnit == PVC_UNITLESS
  ) else $error("ratio of equal units not unitless");

  a_ratio_zero: assert property (
    st_reg.fsm == PVC_S_CALC && funcSel == PVC_F_RATIO && pvIn[1] == '0
      |-> ##[1:200] (validOut && errOut)
  ) else $error("division by zero not flagged");

  a_xover_low: assert property (
    st_reg.fsm == PVC_S_CALC && funcSel == PVC_F_XOVER && aW <= xLo
      |=> st_reg.raw == $past(pvIn[0]) && st_reg.fsm == PVC_S_FILT
  ) else $error("input A not passed below the band");

  a_result_bound: assert property (
    st_reg.fsm == PVC_S_CALC |-> ##[3:200] validOut
  ) else $error("sample result not delivered in time");
endmodule

// [bench/pvc_source_model.sv]
// upstream source model driving the process inputs
`timescale 1ns/1ps
module pvc_source_model
  import pvc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [PVC_NIN-1:0][PVC_DW-1:0] reqPv,
  input wire logic [PVC_NIN-1:0] reqConn,
  output logic [PVC_NIN-1:0][PVC_DW-1:0] pvIn
);
  initial pvIn = '0;
  // a link with no source shows a value that flips every cycle
  always @(negedge core_clk) begin
    for (int i = 0; i < PVC_NIN; i++) begin
      pvIn[i] <= reqConn[i] ? reqPv[i] : ~pvIn[i];
    end
  end
endmodule

// [bench/test_process_value_conditioner.sv]
// self-checking bench for the process value conditioner
`timescale 1ns/1ps
module test_process_value_conditioner;
  import pvc_pkg::*;
  localparam int SC = 200;
  typedef struct {
    logic [2:0] fn;
    logic sel;
    logic [3:0] conn;
    logic [3:0] err;
    logic [31:0] pv0;
    logic [31:0] pv1;
    logic [7:0] un1;
    logic [31:0] off;
    logic [31:0] xv;
    logic [7:0] xu;
    logic xe;
  } pvc_row_t;
  pvc_row_t rows [15];
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0][31:0] reqPv = '0;
  logic [3:0][31:0] pvIn;
  logic [3:0][7:0] unitIn = '0;
  logic [3:0] connIn = '0;
  logic [3:0] errIn = '0;
  logic inputSelectLine = 1'b0;
  logic [2:0] funcSel = '0;
  logic [31:0] offsetSet = '0;
  logic [9:0] filterSet = '0;
  logic [31:0] xoverBand = 32'h0000_07D0;
  logic [7:0] pressSet = 8'h93;
  pvc_row_t hr;
  logic [31:0] pvOut;
  logic [7:0] unitOut;
  logic errOut;
  logic validOut;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;

  pvc_source_model SRC (.core_clk(core_clk), .reqPv(reqPv), .reqConn(connIn), .pvIn(pvIn));
  pvc_conditioner #(.SAMPLE_CYCLES(SC)) DUT (.core_clk(core_clk), .nrst(nrst), .pvIn(pvIn),
    .unitIn(unitIn), .connIn(connIn), .errIn(errIn), .inputSelectLine(inputSelectLine),
    .funcSel(funcSel), .offsetSet(offsetSet), .filterSet(filterSet),
    .xoverPoint(32'h0000_03E8), .xoverBand(xoverBand), .pressSet(pressSet),
    .pvOut(pvOut), .unitOut(unitOut), .errOut(errOut), .validOut(validOut));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task wait_valid();
    n = 0;
    @(negedge core_clk);
    while (validOut !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 400) err_count++;
  endtask

  task apply(input pvc_row_t r);
    wait_valid();
    funcSel <= r.fn;
    inputSelectLine <= r.sel;
    connIn <= r.conn;
    errIn <= r.err;
    reqPv <= {32'h0000_1770, 32'h0000_0FA0, r.pv1, r.pv0};
    unitIn <= {8'h44, 8'h33, r.un1, 8'h11};
    offsetSet <= r.off;
    wait_valid();
    chk("errOut", {31'h0, errOut}, {31'h0, r.xe});
    if (!r.xe) begin
      chk("pvOut", pvOut, r.xv);
      chk("unitOut", {24'h0, unitOut}, {24'h0, r.xu});
    end
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rows = '{
      '{3'h0, 1'b0, 4'hF, 4'h0, 32'h0000_03E8, 32'h0000_07D0, 8'h22, 32'h0000_00FA,
        32'h0000_04E2, 8'h11, 1'b0},
      '{3'h1, 1'b0, 4'hD, 4'h1, 32'h0000_03E8, 32'h0000_07D0, 8'h22, 32'h0, 32'h0000_0FA0,
        8'h33, 1'b0},
      '{3'h2, 1'b0, 4'hB, 4'h0, 32'h0000_03E8, 32'h0000_07D0, 8'h22, 32'h0, 32'h0000_0BB8,
        8'h11, 1'b0},
      '{3'h3, 1'b0, 4'hF, 4'h0, 32'h0000_03E8, 32'h0000_07D0, 8'h22, 32'h0, 32'h0000_05DC,
        8'h11, 1'b0},
      '{3'h3, 1'b0, 4'hF, 4'h0, 32'hFFFF_F830, 32'h0000_07D0, 8'h22, 32'h0, 32'hFFFF_F830,
        8'h11, 1'b0},
      '{3'h3, 1'b0, 4'hF, 4'h0, 32'h0000_1770, 32'h0000_07D0, 8'h22, 32'h0, 32'h0000_07D0,
        8'h11, 1'b0},
      '{3'h4, 1'b0, 4'hF, 4'h0, 32'h0001_1170, 32'h0001_1170, 8'h22, 32'h0, 32'h0001_86A0,
        8'h01, 1'b0},
      '{3'h5, 1'b0, 4'hF, 4'h0, 32'h0000_03E8, 32'h0000_07D0, 8'h22, 32'h0, 32'h0000_03E8,
        8'h11, 1'b0},
      '{3'h5, 1'b1, 4'hF, 4'h0, 32'h0000_03E8, 32'h0000_07D0, 8'h22, 32'h0, 32'h0000_07D0,
        8'h22, 1'b0},
      '{3'h6, 1'b0, 4'hF, 4'h0, 32'h0000_03E8, 32'h0000_07D0, 8'h22, 32'h0, 32'hFFFF_FC18,
        8'h11, 1'b0},
      '{3'h7, 1'b0, 4'hF, 4'h0, 32'h0000_1770, 32'h0000_07D0, 8'h22, 32'h0, 32'h0000_0BB8,
        8'h11, 1'b0},
      '{3'h7, 1'b0, 4'hF, 4'h0, 32'h0000_1770, 32'h0000_07D0, 8'h11, 32'h0, 32'h0000_0BB8,
        8'h00, 1'b0},
      '{3'h7, 1'b0, 4'hF, 4'h0, 32'h0000_1770, 32'h0, 8'h22, 32'h0, 32'h0, 8'h11, 1'b1},
      '{3'h1, 1'b0, 4'hF, 4'hF, 32'h0000_03E8, 32'h0000_07D0, 8'h22, 32'h0, 32'h0, 8'h11,
        1'b1},
      '{3'h0, 1'b0, 4'hF, 4'h0, 32'h0, 32'h0000_07D0, 8'h22, 32'h7FFF_FFFF, 32'h05F5_DD18,
        8'h11, 1'b0}};
    repeat (16) @(negedge core_clk);
    chk("pvOut_in_reset", pvOut, 32'h0);
    chk("validOut_in_reset", {31'h0, validOut}, 32'h0);
    nrst <= 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      apply(rows[i]);
      $display("row %0d done", i);
    end
    // awkward cases: healthy primary, unconnected primary, setting clamps
    hr = '{3'h1, 1'b0, 4'hF, 4'h0, 32'h0000_03E8, 32'h0000_07D0, 8'h22, 32'h0, 32'h0000_03E8,
      8'h11, 1'b0};
    apply(hr);
    hr.conn = 4'hE;
    hr.xv = 32'h0000_07D0;
    hr.xu = 8'h22;
    apply(hr);
    pressSet <= 8'h00;
    hr = '{3'h4, 1'b0, 4'hF, 4'h0, 32'h0001_24F8, 32'h0000_C350, 8'h22, 32'h0, 32'h0000_4D96,
      8'h01, 1'b0};
    apply(hr);
    pressSet <= 8'hFF;
    hr.xv = 32'h0000_1B20;
    apply(hr);
    xoverBand <= 32'hFFFF_F830;
    hr = '{3'h3, 1'b0, 4'hF, 4'h0, 32'h0000_03E8, 32'h0000_07D0, 8'h22, 32'h0, 32'h0000_05DC,
      8'h11, 1'b0};
    apply(hr);
    apply(rows[14]);
    $display("awkward case test done");
    // step with smoothing from a settled zero
    wait_valid();
    filterSet <= 10'h00A;
    offsetSet <= 32'h0;
    reqPv[0] <= 32'h0000_2AF8;
    wait_valid();
    chk("filter_step", pvOut, 32'h0000_03E8);
    wait_valid();
    chk("filter_slow", {31'h0, pvOut > 32'h0000_03E8 && pvOut < 32'h0000_2AF8}, 32'h1);
    $display("filter test done");
    // reset in mid-run, then an unprimed filter reloads at once
    nrst <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("pvOut_mid_reset", pvOut, 32'h0);
    nrst <= 1'b1;
    wait_valid();
    chk("first_result_early", {31'h0, n < 150}, 32'h1);
    chk("filter_reload", pvOut, 32'h0000_2AF8);
    $display("second reset test done");
    results();
  end
endmodule
